// file: shared/pmubl_pkg.sv
// Purpose: constants and types shared by the busy/load/calibration control block
// Assumes: 100 MHz sys_clk, command frames delivered whole by the serial front end
// Notes:   times are kept in their own unit, cycle counts are derived from them

package pmubl_pkg;

    // command address field: {read select, channel_select_bits[3:0], register_group_bits[1:0]}
    localparam int unsigned ADDR_W          = 7;
    localparam int unsigned DATA_W          = 22;
    localparam int unsigned CHAN_N          = 4;
    localparam int unsigned DAC_W           = 16;
    localparam int unsigned ADDR_READ_BIT   = 6;
    localparam int unsigned ADDR_CHAN_LSB   = 2;
    localparam int unsigned ADDR_GROUP_LSB  = 0;

    // register_group_bits
    localparam logic [1:0] GROUP_CTRL   = 2'h0;
    localparam logic [1:0] GROUP_GAIN   = 2'h1;
    localparam logic [1:0] GROUP_OFFSET = 2'h2;
    localparam logic [1:0] GROUP_INPUT  = 2'h3;

    // channel control word fields
    localparam int unsigned CHANNEL_ON_BIT        = 21;
    localparam int unsigned DRIVE_FUNC_LSB        = 19;
    localparam int unsigned CURRENT_RANGE_LSB     = 15;
    localparam int unsigned CURRENT_RANGE_W       = 3;
    localparam int unsigned COMPARE_QTY_BIT       = 7;

    // drive_function_field encodings
    localparam logic [1:0] FUNC_VOLTAGE_FORCING = 2'h0;
    localparam logic [1:0] FUNC_CURRENT_FORCING = 2'h1;
    localparam logic [1:0] FUNC_HIZ_VOLTAGE     = 2'h2;
    localparam logic [1:0] FUNC_HIZ_CURRENT     = 2'h3;

    // data word of the no_effect_command
    localparam logic [DATA_W-1:0] NOP_DATA = 22'h3f_ffff;

    // power-on defaults
    localparam logic [DATA_W-1:0] CTRL_RESET   = 22'h00_0000;
    localparam logic [DATA_W-1:0] SYS_RESET    = 22'h00_0000;
    localparam logic [DAC_W-1:0]  GAIN_RESET   = 16'hffff;
    localparam logic [DAC_W-1:0]  OFFSET_RESET = 16'h8000;
    localparam logic [DAC_W-1:0]  INPUT_RESET  = 16'h0000;
    localparam logic [DAC_W-1:0]  CACHE_RESET  = 16'h0000;
    localparam logic [DAC_W-1:0]  CAL_MIDSCALE = 16'h8000;

    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned STAGE1_NS     = 650;
    localparam int unsigned STAGE2_NS     = 650;
    localparam int unsigned STAGE3_NS     = 350;
    localparam int unsigned SHORT_MAX_NS  = 270;
    localparam int unsigned RESET_US      = 600;

    localparam int unsigned STAGE1_CYC = (STAGE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TAIL_CYC   = (STAGE2_NS + STAGE3_NS + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
    localparam int unsigned SHORT_CYC  = SHORT_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned RESET_CYC  = (RESET_US * 1000) / CLK_PERIOD_NS;

    localparam int unsigned TIMER_W     = 8;
    localparam int unsigned RESET_CNT_W = 20;

    localparam logic [TIMER_W-1:0] STAGE1_LAST = TIMER_W'(STAGE1_CYC - 1);
    localparam logic [TIMER_W-1:0] TAIL_LAST   = TIMER_W'(TAIL_CYC - 1);
    // two cycles of flop latency on the pin are part of the short pulse
    localparam logic [TIMER_W-1:0] SHORT_LAST  = TIMER_W'(SHORT_CYC - 3);

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SHORT  = 3'h1,
        ST_STAGE1 = 3'h2,
        ST_TAIL   = 3'h3,
        ST_RESET  = 3'h4
    } pmubl_state_type;

endpackage : pmubl_pkg

// file: verilog/pmubl_top.sv
// Purpose: command decode, shared calibration engine, wired busy and load control
// Assumes: command frames arrive as one-cycle strobes on sys_clk; pins are asynchronous
// Notes:   busy is open drain: busy_oe high pulls the shared line low

`timescale 1ns/100ps

module pmubl_top
    import pmubl_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = RESET_CYC
) (
    input  wire logic                      sys_clk,
    input  wire logic                      srst,
    input  wire logic [ADDR_W-1:0]         cmd_addr,
    input  wire logic [DATA_W-1:0]         cmd_wdata,
    input  wire logic                      cmd_wr,
    input  wire logic                      cmd_rd,
    output logic      [DATA_W-1:0]         serial_readback_out,
    output logic                           serial_readback_oe,
    input  wire logic                      load_n,
    input  wire logic                      reset_pin_n,
    input  wire logic                      busy_in,
    output logic                           busy_out,
    output logic                           busy_oe,
    output logic      [CHAN_N*DAC_W-1:0]   dac_level,
    output logic      [CHAN_N*DATA_W-1:0]  chan_mode,
    output logic      [DATA_W-1:0]         sys_ctrl
);

    localparam logic [RESET_CNT_W-1:0] RST_LAST = RESET_CNT_W'(RESET_CYCLES - 1);

    pmubl_state_type           state_q;
    logic [TIMER_W-1:0]        timer_q;
    logic [RESET_CNT_W-1:0]    rst_cnt_q;
    logic [CHAN_N-1:0]         cal_mask_q;
    logic [1:0]                chan_idx_q;

    logic                      load_s1_q;
    logic                      load_s2_q;
    logic                      rst_s1_q;
    logic                      rst_s2_q;
    logic                      rst_prev_q;
    logic                      busy_s1_q;
    logic                      busy_s2_q;

    logic [DAC_W-1:0]          dac_input_reg_q [CHAN_N];
    logic [DAC_W-1:0]          gain_q [CHAN_N];
    logic [DAC_W-1:0]          offset_q [CHAN_N];
    logic [DAC_W-1:0]          cached_corrected_value_q [CHAN_N];
    logic [DATA_W-1:0]         ctrl_q [CHAN_N];
    logic [CHAN_N-1:0]         apply_pend_q;
    logic                      load_req_q;

    logic [DATA_W-1:0]         sys_ctrl_q;
    logic [CHAN_N*DAC_W-1:0]   dac_level_q;
    logic [CHAN_N*DATA_W-1:0]  chan_mode_q;
    logic [DATA_W-1:0]         rdata_q;
    logic                      rd_oe_q;
    logic                      busy_oe_q;
    logic                      busy_out_q;

    logic                      wipe;
    logic                      frame;
    logic                      is_read;
    logic                      wr;
    logic [CHAN_N-1:0]         channel_select_bits;
    logic [1:0]                register_group_bits;
    logic                      zero_mask;
    logic                      no_effect_command;
    logic                      reserved_cmd;
    logic                      wr_ctrl;
    logic                      wr_gain;
    logic                      wr_offset;
    logic                      wr_input;
    logic                      wr_sys;
    logic                      short_trig;
    logic [CHAN_N-1:0]         cal_req;
    logic                      stage_done;
    logic [CHAN_N-1:0]         mask_after;
    logic                      rst_fall;
    logic                      apply_now;
    logic [DATA_W-1:0]         read_mux;
    logic [1:0]                read_idx;

    function automatic logic [1:0] lowest(input logic [CHAN_N-1:0] m);
        logic [1:0] r;
        r = 2'h0;
        if (m[0]) begin
            r = 2'h0;
        end else if (m[1]) begin
            r = 2'h1;
        end else if (m[2]) begin
            r = 2'h2;
        end else if (m[3]) begin
            r = 2'h3;
        end
        return r;
    endfunction : lowest

    // gain and offset correction of one input code
    function automatic logic [DAC_W-1:0] calc(input logic [DAC_W-1:0] x,
                                              input logic [DAC_W-1:0] m,
                                              input logic [DAC_W-1:0] c);
        logic [32:0]      prod;
        logic [DAC_W-1:0] scaled;
        prod   = 33'(x) * 33'({1'b0, m} + 17'h0_0001);
        scaled = prod[31:16];
        return DAC_W'(scaled + c - CAL_MIDSCALE);
    endfunction : calc

    function automatic logic needs_cal(input logic [DATA_W-1:0] old_w,
                                       input logic [DATA_W-1:0] new_w);
        logic [1:0] fo;
        logic [1:0] fn;
        logic       quick;
        fo    = old_w[DRIVE_FUNC_LSB +: 2];
        fn    = new_w[DRIVE_FUNC_LSB +: 2];
        quick = (fo == fn)
              | ({fo, fn} == {FUNC_HIZ_CURRENT, FUNC_CURRENT_FORCING})
              | ({fo, fn} == {FUNC_CURRENT_FORCING, FUNC_HIZ_CURRENT})
              | ({fo, fn} == {FUNC_HIZ_VOLTAGE, FUNC_VOLTAGE_FORCING})
              | ({fo, fn} == {FUNC_VOLTAGE_FORCING, FUNC_HIZ_VOLTAGE});
        return ~quick
             | (old_w[CURRENT_RANGE_LSB +: CURRENT_RANGE_W]
                != new_w[CURRENT_RANGE_LSB +: CURRENT_RANGE_W])
             | (old_w[COMPARE_QTY_BIT] != new_w[COMPARE_QTY_BIT]);
    endfunction : needs_cal

    // pin synchronisers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            load_s1_q  <= 1'b1;
            load_s2_q  <= 1'b1;
            rst_s1_q   <= 1'b1;
            rst_s2_q   <= 1'b1;
            rst_prev_q <= 1'b1;
            busy_s1_q  <= 1'b1;
            busy_s2_q  <= 1'b1;
        end else begin
            load_s1_q  <= load_n;
            load_s2_q  <= load_s1_q;
            rst_s1_q   <= reset_pin_n;
            rst_s2_q   <= rst_s1_q;
            rst_prev_q <= rst_s2_q;
            busy_s1_q  <= busy_in;
            busy_s2_q  <= busy_s1_q;
        end
    end

    // command decode
    always_comb begin
        wipe                = srst | (state_q == ST_RESET);
        frame               = (cmd_wr | cmd_rd) & ~wipe;
        is_read             = cmd_rd | cmd_addr[ADDR_READ_BIT];
        wr                  = frame & ~is_read;
        channel_select_bits = cmd_addr[ADDR_CHAN_LSB +: CHAN_N];
        register_group_bits = cmd_addr[ADDR_GROUP_LSB +: 2];
        zero_mask           = (channel_select_bits == 4'h0);
        no_effect_command   = zero_mask & (register_group_bits == GROUP_INPUT)
                            & (cmd_wdata == NOP_DATA);
        reserved_cmd        = wr & zero_mask & (register_group_bits != GROUP_CTRL)
                            & ~no_effect_command;
        wr_sys              = wr & zero_mask & (register_group_bits == GROUP_CTRL);
        wr_ctrl             = wr & ~zero_mask & (register_group_bits == GROUP_CTRL);
        wr_gain             = wr & ~zero_mask & (register_group_bits == GROUP_GAIN);
        wr_offset           = wr & ~zero_mask & (register_group_bits == GROUP_OFFSET);
        wr_input            = wr & ~zero_mask & (register_group_bits == GROUP_INPUT);
        short_trig          = frame & ~reserved_cmd;
        rst_fall            = rst_prev_q & ~rst_s2_q;
        stage_done          = (state_q == ST_STAGE1) && (timer_q == STAGE1_LAST);
        apply_now           = load_req_q & ~busy_oe_q & busy_s2_q
                            & (state_q == ST_IDLE);
        for (int i = 0; i < CHAN_N; i++) begin
            cal_req[i] = channel_select_bits[i]
                       & (wr_input | (wr_ctrl & needs_cal(ctrl_q[i], cmd_wdata)));
        end
        mask_after = cal_mask_q | cal_req;
        if (stage_done) begin
            mask_after = (cal_mask_q & ~(4'h1 << chan_idx_q)) | cal_req;
        end
    end

    // engine sequencing and reset sequence
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q    <= ST_RESET;
            timer_q    <= '0;
            rst_cnt_q  <= '0;
            cal_mask_q <= '0;
            chan_idx_q <= 2'h0;
        end else if (rst_fall && state_q != ST_RESET) begin
            state_q    <= ST_RESET;
            timer_q    <= '0;
            rst_cnt_q  <= '0;
            cal_mask_q <= '0;
        end else begin
            unique case (state_q)
                ST_RESET: begin
                    cal_mask_q <= '0;
                    if (rst_cnt_q != RST_LAST) begin
                        rst_cnt_q <= rst_cnt_q + 1'b1;
                    end else if (rst_s2_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE, ST_SHORT: begin
                    cal_mask_q <= mask_after;
                    if (|mask_after) begin
                        state_q    <= ST_STAGE1;
                        timer_q    <= '0;
                        chan_idx_q <= lowest(mask_after);
                    end else if (short_trig) begin
                        state_q <= ST_SHORT;
                        timer_q <= '0;
                    end else if (state_q == ST_SHORT) begin
                        if (timer_q == SHORT_LAST) begin
                            state_q <= ST_IDLE;
                        end else begin
                            timer_q <= timer_q + 1'b1;
                        end
                    end
                end
                ST_STAGE1: begin
                    cal_mask_q <= mask_after;
                    if (stage_done) begin
                        timer_q <= '0;
                        if (|mask_after) begin
                            chan_idx_q <= lowest(mask_after);
                        end else begin
                            state_q <= ST_TAIL;
                        end
                    end else begin
                        timer_q <= timer_q + 1'b1;
                    end
                end
                ST_TAIL: begin
                    cal_mask_q <= mask_after;
                    if (timer_q == TAIL_LAST) begin
                        timer_q <= '0;
                        if (|mask_after) begin
                            state_q    <= ST_STAGE1;
                            chan_idx_q <= lowest(mask_after);
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end else begin
                        timer_q <= timer_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    timer_q <= '0;
                end
            endcase
        end
    end

    // open-drain busy drive
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy_oe_q  <= 1'b1;
            busy_out_q <= 1'b0;
        end else begin
            busy_oe_q  <= (state_q != ST_IDLE);
            busy_out_q <= 1'b0;
        end
    end

    // channel registers
    always_ff @(posedge sys_clk) begin
        if (wipe) begin
            for (int i = 0; i < CHAN_N; i++) begin
                ctrl_q[i]          <= CTRL_RESET;
                gain_q[i]          <= GAIN_RESET;
                offset_q[i]        <= OFFSET_RESET;
                dac_input_reg_q[i] <= INPUT_RESET;
            end
        end else begin
            for (int i = 0; i < CHAN_N; i++) begin
                if (channel_select_bits[i]) begin
                    if (wr_ctrl) begin
                        ctrl_q[i] <= cmd_wdata;
                    end
                    if (wr_gain) begin
                        gain_q[i] <= cmd_wdata[DAC_W-1:0];
                    end
                    if (wr_offset) begin
                        offset_q[i] <= cmd_wdata[DAC_W-1:0];
                    end
                    if (wr_input) begin
                        dac_input_reg_q[i] <= cmd_wdata[DAC_W-1:0];
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wipe) begin
            sys_ctrl_q <= SYS_RESET;
        end else if (wr_sys) begin
            sys_ctrl_q <= cmd_wdata;
        end
    end

    // cached value written at the end of each channel's first stage
    always_ff @(posedge sys_clk) begin
        if (wipe) begin
            for (int i = 0; i < CHAN_N; i++) begin
                cached_corrected_value_q[i] <= CACHE_RESET;
            end
        end else if (stage_done) begin
            cached_corrected_value_q[chan_idx_q] <= calc(dac_input_reg_q[chan_idx_q],
                                                         gain_q[chan_idx_q],
                                                         offset_q[chan_idx_q]);
        end
    end

    // pending updates and latched load request
    always_ff @(posedge sys_clk) begin
        if (wipe) begin
            apply_pend_q <= '0;
            load_req_q   <= 1'b0;
        end else begin
            apply_pend_q <= (apply_now ? 4'h0 : apply_pend_q)
                          | (wr_ctrl ? channel_select_bits : 4'h0);
            load_req_q   <= (load_req_q & ~apply_now) | ~load_s2_q;
        end
    end

    // dac_level and chan_mode change only on a load, and clear on a wipe
    always_ff @(posedge sys_clk) begin
        if (wipe) begin
            dac_level_q <= '0;
            chan_mode_q <= '0;
        end else if (apply_now) begin
            for (int i = 0; i < CHAN_N; i++) begin
                if (apply_pend_q[i]) begin
                    dac_level_q[i*DAC_W +: DAC_W]   <= cached_corrected_value_q[i];
                    chan_mode_q[i*DATA_W +: DATA_W] <= ctrl_q[i];
                end
            end
        end
    end

    // readback
    always_comb begin
        read_idx = lowest(channel_select_bits);
        read_mux = '0;
        if (zero_mask) begin
            if (register_group_bits == GROUP_CTRL) begin
                read_mux = sys_ctrl_q;
            end
        end else begin
            unique case (register_group_bits)
                GROUP_CTRL:   read_mux = ctrl_q[read_idx];
                GROUP_GAIN:   read_mux = {6'h00, gain_q[read_idx]};
                GROUP_OFFSET: read_mux = {6'h00, offset_q[read_idx]};
                GROUP_INPUT:  read_mux = {6'h00, dac_input_reg_q[read_idx]};
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wipe) begin
            rdata_q <= '0;
            rd_oe_q <= 1'b0;
        end else begin
            rd_oe_q <= frame & is_read;
            rdata_q <= (frame & is_read) ? read_mux : '0;
        end
    end

    assign serial_readback_out = rdata_q;
    assign serial_readback_oe  = rd_oe_q;
    assign busy_out            = busy_out_q;
    assign busy_oe             = busy_oe_q;
    assign dac_level           = dac_level_q;
    assign chan_mode           = chan_mode_q;
    assign sys_ctrl            = sys_ctrl_q;

endmodule : pmubl_top

// file: tb/pmubl_top_properties.sv
// Purpose: port assertions for pmubl_top
// Assumes: one clock domain, srst synchronous
// Notes:   bound to every pmubl_top below
`timescale 1ns/100ps
module pmubl_chk
    import pmubl_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = RESET_CYC
) (
    input wire logic                     sys_clk,
    input wire logic                     srst,
    input wire logic [ADDR_W-1:0]        cmd_addr,
    input wire logic                     cmd_wr,
    input wire logic                     cmd_rd,
    input wire logic                     serial_readback_oe,
    input wire logic                     reset_pin_n,
    input wire logic                     busy_in,
    input wire logic                     busy_oe,
    input wire logic [CHAN_N*DAC_W-1:0]  dac_level,
    input wire logic [CHAN_N*DATA_W-1:0] chan_mode
);
    localparam int LIM = (RESET_CYCLES + 8 > 360) ? RESET_CYCLES + 8 : 360;
    int cnt_q;
    // length of the current busy pulse
    always_ff @(posedge sys_clk) begin
        cnt_q <= (busy_oe && !srst) ? cnt_q + 1 : 0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    chk_read_answer: assert property (cmd_rd && !busy_oe |=> serial_readback_oe)
        else $error("read not answered");
    chk_oe_cause: assert property (serial_readback_oe |->
        $past(cmd_rd || (cmd_wr && cmd_addr[ADDR_READ_BIT])))
        else $error("readback driven without read");
    chk_reset_state: assert property (disable iff (1'h0)
        srst |=> busy_oe && !serial_readback_oe)
        else $error("reset state wrong");
    chk_write_busy: assert property (cmd_wr && !busy_oe && cmd_addr[5:2] != 4'h0 |->
        ##2 busy_oe)
        else $error("write did not pull busy");
    chk_short_busy: assert property (cmd_wr && !busy_oe && cmd_addr == 7'h00 |->
        ##2 busy_oe ##[1:26] !busy_oe)
        else $error("short busy pulse wrong");
    chk_cal_time: assert property (cmd_wr && !busy_oe && cmd_addr == 7'h07 |->
        ##166 busy_oe ##1 !busy_oe)
        else $error("one channel busy pulse wrong");
    chk_busy_max: assert property (busy_oe |-> cnt_q < LIM)
        else $error("busy pulse too long");
    chk_apply_gate: assert property (($changed(dac_level) || $changed(chan_mode))
        && chan_mode != '0 |-> $past(!busy_oe && busy_in))
        else $error("update while busy line low");
    chk_pin_reset: assert property ($fell(reset_pin_n) && !busy_oe |-> ##[1:6] busy_oe)
        else $error("reset pin fall not seen");
    cover property (cmd_wr && cmd_addr == 7'h3f);
    cover property ($fell(busy_oe));
    cover property ($changed(chan_mode));
endmodule : pmubl_chk
bind pmubl_top pmubl_chk #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.sys_clk(sys_clk),
    .srst(srst), .cmd_addr(cmd_addr), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .serial_readback_oe(serial_readback_oe), .reset_pin_n(reset_pin_n),
    .busy_in(busy_in), .busy_oe(busy_oe), .dac_level(dac_level), .chan_mode(chan_mode));

// file: tb/pmubl_host_model.sv
// Purpose: host pins and a second device on the wired busy line
// Assumes: requests change right after a clock edge
// Notes:   busy line has a pull-up
`timescale 1ns/100ps
module pmubl_host_model (
    input  wire logic load_req,
    input  wire logic reset_req,
    input  wire logic hold_busy,
    input  wire logic dut_busy_oe,
    output logic      load_n,
    output logic      reset_pin_n,
    output logic      busy_line,
    output logic      frame_ok
);
    assign load_n = !load_req;
    assign reset_pin_n = !reset_req;
    // low while any device pulls, else pulled up
    assign busy_line = !(hold_busy || dut_busy_oe);
    assign frame_ok = busy_line;
endmodule : pmubl_host_model

// file: tb/pmubl_top_tb_top.sv
// Purpose: directed scenarios for pmubl_top
// Assumes: short reset sequence via RESET_CYCLES
// Notes:   short busy accepted as 1 to 27 cycles
`timescale 1ns/100ps
module pmubl_top_tb_top
    import pmubl_pkg::*;
;
    logic sys_clk = 0, srst = 1, cmd_wr = 0, cmd_rd = 0, ld = 0, rp = 0, hold = 0;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_wdata = '0;
    logic load_n, reset_pin_n, busy_line, frame_ok, busy_oe, ro_oe, bo;
    logic [DATA_W-1:0] ro, sys_ctrl;
    logic [CHAN_N*DAC_W-1:0] dac;
    logic [CHAN_N*DATA_W-1:0] mode;
    int fails = 0, n_tests = 0, n;
    always #5 sys_clk = !sys_clk;
    pmubl_top #(.RESET_CYCLES(20)) dut (.sys_clk(sys_clk), .srst(srst), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .serial_readback_out(ro),
        .serial_readback_oe(ro_oe), .load_n(load_n), .reset_pin_n(reset_pin_n),
        .busy_in(busy_line), .busy_out(bo), .busy_oe(busy_oe), .dac_level(dac),
        .chan_mode(mode), .sys_ctrl(sys_ctrl));
    pmubl_host_model host (.load_req(ld), .reset_req(rp), .hold_busy(hold),
        .dut_busy_oe(busy_oe), .load_n(load_n), .reset_pin_n(reset_pin_n),
        .busy_line(busy_line), .frame_ok(frame_ok));
    task close_out;
        if (fails == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    task chk(input string s, input logic [191:0] seen, input logic [191:0] e);
        n_tests++;
        if (seen !== e) begin
            fails++;
            $display("mismatch %s exp %h seen %h", s, e, seen);
        end
    endtask : chk
    task cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : cyc
    // short pulses map to 0, others keep their length
    function int lenc(input int k);
        return (k > 0 && k <= 27) ? 0 : k;
    endfunction : lenc
    task wr(input logic [6:0] a, input logic [21:0] d);
        while (!frame_ok) @(posedge sys_clk);
        @(posedge sys_clk);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'h1;
        @(posedge sys_clk);
        cmd_wr <= 1'h0;
    endtask : wr
    task meas;
        n = 0;
        repeat (420) begin
            @(negedge sys_clk);
            n += int'(busy_oe === 1'h1);
        end
        @(posedge sys_clk);
    endtask : meas
    task pulse_load;
        ld <= 1'h1;
        cyc(8);
        ld <= 1'h0;
        cyc(8);
    endtask : pulse_load
    task t_basic;
        meas;
        chk("defaults", {mode, dac, sys_ctrl}, '0);
        wr(7'h00, 22'h00_1234);
        meas;
        chk("sys_busy", lenc(n), 0);
        chk("sys_ctrl", sys_ctrl, 22'h00_1234);
        @(posedge sys_clk);
        cmd_addr <= 7'h40;
        cmd_rd <= 1'h1;
        @(posedge sys_clk);
        cmd_rd <= 1'h0;
        #1;
        chk("readback", {ro_oe, ro}, {1'h1, 22'h00_1234});
        meas;
    endtask : t_basic
    task t_cal;
        wr(7'h07, 22'h00_1234);
        meas;
        chk("cal_one", n, 165);
        pulse_load;
        chk("cache_held", dac, '0);
        wr(7'h04, 22'h20_0000);
        meas;
        chk("enable_busy", lenc(n), 0);
        pulse_load;
        chk("apply", {mode[21:0], dac[15:0]}, {22'h20_0000, 16'h1234});
        wr(7'h3f, 22'h00_0001);
        meas;
        chk("cal_four", n, 360);
    endtask : t_cal
    task t_defer;
        wr(7'h08, 22'h20_0000);
        hold <= 1'h1;
        cyc(3);
        pulse_load;
        cyc(100);
        chk("held_by_line", mode[43:22], '0);
        hold <= 1'h0;
        cyc(10);
        chk("late_apply", mode[43:22], 22'h20_0000);
    endtask : t_defer
    task t_modes;
        logic [21:0] w[6] = '{22'h10_0000, 22'h18_0000, 22'h08_0000,
                              22'h00_0000, 22'h00_8000, 22'h00_8080};
        int e[6] = '{0, 165, 0, 165, 165, 165};
        logic [151:0] snap;
        for (int i = 0; i < 6; i++) begin
            wr(7'h10, w[i]);
            meas;
            chk("mode_busy", lenc(n), e[i]);
        end
        pulse_load;
        chk("mode_apply", {mode[65:44], dac[47:32]}, {22'h00_8080, 16'h0001});
        snap = {mode, dac};
        wr(7'h03, 22'h3f_ffff);
        meas;
        chk("nop_busy", lenc(n), 0);
        wr(7'h01, 22'h00_0005);
        meas;
        chk("reserved", n, 0);
        pulse_load;
        chk("nop_keep", {mode, dac}, snap);
    endtask : t_modes
    task t_pin;
        rp <= 1'h1;
        cyc(10);
        chk("pin_busy", {busy_oe, bo}, 2'h2);
        cmd_addr <= 7'h40;
        cmd_rd <= 1'h1;
        cyc(1);
        cmd_rd <= 1'h0;
        #1;
        chk("pin_quiet", ro_oe, 1'h0);
        cyc(20);
        rp <= 1'h0;
        meas;
        chk("pin_clear", {mode, dac, sys_ctrl}, '0);
    endtask : t_pin
    initial begin
        cyc(3);
        srst <= 1'h0;
        t_basic;
        t_cal;
        t_defer;
        t_modes;
        t_pin;
        close_out;
    end
    initial begin
        cyc(20000);
        fails++;
        close_out;
    end
endmodule : pmubl_top_tb_top
